/* File: csc_pkg.sv */
// Shared constants, carriers and decoders for the charger status and setup registers
package csc_pkg;

    // Register offsets on the serial-interface register port
    localparam logic [7:0] CSC_ADDR_CONDITION = 8'h03;
    localparam logic [7:0] CSC_ADDR_SETUP     = 8'h04;

    // Reset values
    localparam logic [7:0] CSC_SETUP_RESET     = 8'hB1;
    localparam logic [7:0] CSC_CONDITION_RESET = 8'h00;
    localparam logic [7:0] CSC_UNMAPPED_READ   = 8'h00;

    // Field positions of charger_condition
    localparam int COND_THERMAL_REG_BIT = 7;
    localparam int COND_POWER_PATH_BIT  = 6;
    localparam int COND_THERM_TIMER_SUSPEND_BIT  = 5;
    localparam int COND_TERM_BIT        = 4;
    localparam int COND_ACTIVE_BIT      = 3;
    localparam int COND_CHG_TOUT_BIT    = 2;
    localparam int COND_PRE_TOUT_BIT    = 1;
    localparam int COND_BATT_TEMP_BIT   = 0;

    // Field positions of charger_setup
    localparam int SETUP_TIMER_MSB      = 7;
    localparam int SETUP_TIMER_LSB      = 6;
    localparam int SETUP_SAFETY_TIMER_ENABLE_BIT     = 5;
    localparam int SETUP_NTC_BIT        = 4;
    localparam int SETUP_RESTART_BIT    = 3;
    localparam int SETUP_TERM_DIS_BIT   = 2;
    localparam int SETUP_TIMER_SUSPEND_BIT       = 1;
    localparam int SETUP_CHARGER_ENABLE_BIT     = 0;

    // Timing: one-second tick derived from the 8 ns clock
    localparam int CLK_PERIOD_NS        = 8;
    localparam int TICK_TIME_MS         = 1000;
    localparam int TICK_CYCLES          = (TICK_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam int SEC_PER_MIN          = 60;

    // Safety timer durations in minutes
    localparam int FAST_4H_MIN          = 240;
    localparam int FAST_5H_MIN          = 300;
    localparam int FAST_6H_MIN          = 360;
    localparam int FAST_8H_MIN          = 480;
    localparam int PRE_SHORT_MIN        = 30;
    localparam int PRE_LONG_MIN         = 60;

    // Width of the seconds counters (8 h = 28800 s fits)
    localparam int SEC_W                = 16;

    // Conditioned analog comparator outputs from the charger core
    typedef struct packed {
        logic thermal_reg;         // Die-temperature loop cutting current
        logic power_path;          // Input-limiting loop cutting current
        logic temp_out_of_range;   // Battery outside charging window
        logic no_thermistor;       // Sensor missing
        logic term_current;        // Charge current below termination level
        logic batt_low;            // Battery below precharge threshold
        logic supply_good;         // A valid input supply is present
    } csc_analog_t;

    // Charge algorithm phases
    typedef enum logic [1:0] {
        CSC_IDLE    = 2'b00,
        CSC_PRECHG  = 2'b01,
        CSC_FASTCHG = 2'b10,
        CSC_DONE    = 2'b11
    } csc_state_t;

    // Fast-charge limit in seconds from the two-bit code
    function automatic logic [SEC_W-1:0] csc_fast_limit(input logic [1:0] code);
        unique case (code)
            2'b00: csc_fast_limit = SEC_W'(FAST_4H_MIN * SEC_PER_MIN);
            2'b01: csc_fast_limit = SEC_W'(FAST_5H_MIN * SEC_PER_MIN);
            2'b10: csc_fast_limit = SEC_W'(FAST_6H_MIN * SEC_PER_MIN);
            2'b11: csc_fast_limit = SEC_W'(FAST_8H_MIN * SEC_PER_MIN);
        endcase
    endfunction

    // Precharge limit in seconds from the select bit
    function automatic logic [SEC_W-1:0] csc_pre_limit(input logic sel);
        csc_pre_limit = sel ? SEC_W'(PRE_LONG_MIN * SEC_PER_MIN) : SEC_W'(PRE_SHORT_MIN * SEC_PER_MIN);
    endfunction

endpackage

/* File: csc_timer.sv */
// Seconds counter with freeze and clear, flags once its limit is reached
module csc_timer (
    // Clock and reset
    input  wire logic                      ref_clk_i,
    input  wire logic                      resetn_i,
    // Control
    input  wire logic                      clear_i,
    input  wire logic                      step_i,
    input  wire logic [csc_pkg::SEC_W-1:0] limit_i,
    // Result
    output logic                           expired_o
);
    import csc_pkg::*;

    logic [SEC_W-1:0] count_q;   // Elapsed seconds
    logic [SEC_W-1:0] count_inc; // Next count when stepping

    assign count_inc = count_q + SEC_W'(1);

    // Count only on steps; the count saturates once expired so it never wraps
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i || clear_i) begin
            count_q   <= '0;
            expired_o <= 1'b0;
        end else if (step_i && !expired_o) begin
            count_q   <= count_inc;
            expired_o <= (count_inc >= limit_i);
        end
    end

endmodule // csc_timer

/* File: csc_regs.sv */
// Charger condition/setup registers and the charge-phase control they steer
import csc_pkg::*;

// What this block does
// RULE1: Bit 7 shows die-temperature current cutback
// RULE2: Bit 6 shows input-limit loop cutting current
// RULE3: Bit 5 shows charging paused by battery temperature
// RULE4: Bit 4 shows termination current reached, stopped
// RULE5: Bit 3 shows charger delivering current
// RULE6: Bit 2 set on any timer expiry; stop
// RULE7: Bit 1 set on precharge expiry; stop
// RULE8: Bit 0 shows missing sensor or bad temperature
// RULE9: Bits 7:6 pick 4/5/6/8 h, reset 10b
// RULE10: Bit 5 enables both timers, reset 1
// RULE11: Bit 4 picks thermistor curve, reset 1
// RULE12: Host sets then clears bit 3 to restart
// RULE13: Bit 2 disables current-based termination only
// RULE14: Bit 1 freezes both timers
// RULE15: Bit 0 enables charger, reset 1
// RULE16: Setup register at 0x04, resets to 0xB1
// RULE17: Precharge timer is 30 or 60 minutes
// RULE18: Status bits live, read-only, not read-cleared
module csc_regs #(
    parameter int TICK_CYCLES_P = csc_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 resetn_i,
    // Register port from the serial interface
    input  wire logic [7:0]           reg_addr_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    input  wire logic [7:0]           reg_wdata_i,
    output logic      [7:0]           reg_rdata_o,
    // Charger core status (asynchronous)
    input  wire csc_pkg::csc_analog_t analog_i,
    // Precharge time select from another setup register (same clock)
    input  wire logic                 precharge_time_select_i,
    // Controls to the charger core
    output logic                      charge_on_o,
    output logic                      thermistor_type_select_o
);
    import csc_pkg::*;

    csc_analog_t      ana_meta_q;       // First synchroniser stage
    csc_analog_t      ana_q;            // Synchronised analog status
    logic [7:0]       setup_q;          // charger_setup contents
    logic [7:0]       cond_q;           // charger_condition contents
    csc_state_t       state_q;          // Charge phase
    logic [31:0]      tick_cnt_q;       // Cycles within the current second
    logic             sec_tick_q;       // One-cycle pulse per second
    logic             term_q;           // Current termination reached
    logic             chg_tout_q;       // Some safety timer expired
    logic             pre_tout_q;       // Precharge timer expired
    logic             pre_exp;          // Precharge timer at limit
    logic             fast_exp;         // Fast-charge timer at limit
    logic             timer_step;       // Timers advance this cycle
    logic             halt;             // Charger forced idle
    logic             charging;         // In a charging phase
    logic             temp_bad;         // Battery temperature fault
    logic             deliver;          // Current actually flowing
    logic             ev_term;          // Termination event
    logic             ev_fast_tout;     // Fast-charge expiry event
    logic             ev_pre_tout;      // Precharge expiry event
    logic [SEC_W-1:0] pre_limit;        // Precharge duration, seconds
    logic [SEC_W-1:0] fast_limit;       // Fast-charge duration, seconds

    // Setup field aliases
    logic [1:0] fast_timer_sel;
    logic       safety_timer_enable;
    logic       thermistor_type_select;
    logic       charger_restart;
    logic       term_disable;
    logic       timer_suspend;
    logic       charger_enable;

    assign fast_timer_sel         = setup_q[SETUP_TIMER_MSB:SETUP_TIMER_LSB];
    assign safety_timer_enable    = setup_q[SETUP_SAFETY_TIMER_ENABLE_BIT];
    assign thermistor_type_select = setup_q[SETUP_NTC_BIT];
    assign charger_restart        = setup_q[SETUP_RESTART_BIT];
    assign term_disable           = setup_q[SETUP_TERM_DIS_BIT];
    assign timer_suspend          = setup_q[SETUP_TIMER_SUSPEND_BIT];
    assign charger_enable         = setup_q[SETUP_CHARGER_ENABLE_BIT];

    // Analog status crosses in through two flops before any use
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            ana_meta_q <= '0;
            ana_q      <= '0;
        end else begin
            ana_meta_q <= analog_i;
            ana_q      <= ana_meta_q;
        end
    end

    // Setup register: all bits writable, status offset takes no write
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            setup_q <= CSC_SETUP_RESET; // RULE16 RULE9 RULE10 RULE11 RULE15
        end else if (reg_wr_i && reg_addr_i == CSC_ADDR_SETUP) begin
            setup_q <= reg_wdata_i; // RULE16
        end
    end

    // Restart is level-held by the host, so it parks the charger like a disable
    assign halt     = charger_restart || !charger_enable || !ana_q.supply_good; // RULE12 RULE15
    assign charging = (state_q == CSC_PRECHG) || (state_q == CSC_FASTCHG);
    assign temp_bad = ana_q.temp_out_of_range || ana_q.no_thermistor; // RULE8
    assign deliver  = charging && !temp_bad; // RULE5

    // Expiry only counts while the timers are enabled
    assign ev_pre_tout  = (state_q == CSC_PRECHG) && pre_exp && safety_timer_enable && !halt; // RULE7 RULE10
    assign ev_fast_tout = (state_q == CSC_FASTCHG) && fast_exp && safety_timer_enable && !halt; // RULE6 RULE10
    // Current-based stop is skipped when termination is disabled
    assign ev_term      = (state_q == CSC_FASTCHG) && ana_q.term_current && !term_disable
                          && !halt && !ev_fast_tout; // RULE4 RULE13

    // Free-running one-second prescaler for the safety timers
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            tick_cnt_q <= '0;
            sec_tick_q <= 1'b0;
        end else if (tick_cnt_q == 32'(TICK_CYCLES_P - 1)) begin
            tick_cnt_q <= '0;
            sec_tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
            sec_tick_q <= 1'b0;
        end
    end

    // Timers run only while current flows; suspend or disable freezes them
    assign timer_step = sec_tick_q && deliver && safety_timer_enable && !timer_suspend; // RULE14 RULE10
    assign pre_limit  = csc_pre_limit(precharge_time_select_i); // RULE17
    assign fast_limit = csc_fast_limit(fast_timer_sel); // RULE9

    // Precharge timer restarts on each entry to the precharge phase
    csc_timer u_pre_timer (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .clear_i   (state_q != CSC_PRECHG),
        .step_i    (timer_step),
        .limit_i   (pre_limit),
        .expired_o (pre_exp)
    );

    // Fast-charge timer restarts on each entry to the fast phase
    csc_timer u_fast_timer (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .clear_i   (state_q != CSC_FASTCHG),
        .step_i    (timer_step),
        .limit_i   (fast_limit),
        .expired_o (fast_exp)
    );

    // Charge phase sequencing
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            state_q <= CSC_IDLE;
        end else if (halt) begin
            state_q <= CSC_IDLE; // RULE12 RULE15
        end else begin
            unique case (state_q)
                CSC_IDLE: begin
                    state_q <= ana_q.batt_low ? CSC_PRECHG : CSC_FASTCHG;
                end
                CSC_PRECHG: begin
                    // Expiry wins over reaching the fast-charge threshold
                    if (ev_pre_tout) begin
                        state_q <= CSC_DONE; // RULE7
                    end else if (!ana_q.batt_low) begin
                        state_q <= CSC_FASTCHG;
                    end
                end
                CSC_FASTCHG: begin
                    if (ev_fast_tout || ev_term) begin
                        state_q <= CSC_DONE; // RULE6 RULE4
                    end
                end
                CSC_DONE: begin
                    // Terminated until the host restarts or disables the charger, or the supply drops
                    state_q <= CSC_DONE;
                end
            endcase
        end
    end

    // Termination and timeout flags hold until the charger is halted
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i || halt) begin
            term_q     <= 1'b0;
            chg_tout_q <= 1'b0;
            pre_tout_q <= 1'b0;
        end else begin
            if (ev_term) begin
                term_q <= 1'b1; // RULE4
            end
            if (ev_fast_tout || ev_pre_tout) begin
                chg_tout_q <= 1'b1; // RULE6
            end
            if (ev_pre_tout) begin
                pre_tout_q <= 1'b1; // RULE7
            end
        end
    end

    // Condition register tracks live state every cycle; host writes never land here
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            cond_q <= CSC_CONDITION_RESET;
        end else begin
            cond_q[COND_THERMAL_REG_BIT] <= deliver && ana_q.thermal_reg; // RULE1 RULE18
            cond_q[COND_POWER_PATH_BIT]  <= deliver && ana_q.power_path; // RULE2
            cond_q[COND_THERM_TIMER_SUSPEND_BIT]  <= charging && temp_bad; // RULE3
            cond_q[COND_TERM_BIT]        <= term_q; // RULE4
            cond_q[COND_ACTIVE_BIT]      <= deliver; // RULE5
            cond_q[COND_CHG_TOUT_BIT]    <= chg_tout_q; // RULE6
            cond_q[COND_PRE_TOUT_BIT]    <= pre_tout_q; // RULE7
            cond_q[COND_BATT_TEMP_BIT]   <= temp_bad; // RULE8
        end
    end

    // Outputs to the charger core come straight from flops
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            charge_on_o              <= 1'b0;
            thermistor_type_select_o <= CSC_SETUP_RESET[SETUP_NTC_BIT];
        end else begin
            charge_on_o              <= deliver; // RULE5
            thermistor_type_select_o <= thermistor_type_select; // RULE11
        end
    end

    // Read data is registered; a read has no side effect on either register
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= CSC_UNMAPPED_READ;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                CSC_ADDR_CONDITION: reg_rdata_o <= cond_q; // RULE18
                CSC_ADDR_SETUP:     reg_rdata_o <= setup_q;
                default:            reg_rdata_o <= CSC_UNMAPPED_READ;
            endcase
        end
    end

    property p_thermal_reg;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        deliver && ana_q.thermal_reg |=> cond_q[COND_THERMAL_REG_BIT];
    endproperty
    a_thermal_reg: assert property (p_thermal_reg) else $error("thermal flag missed"); // RULE1

    property p_power_path;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !deliver |=> !cond_q[COND_POWER_PATH_BIT] && !cond_q[COND_THERMAL_REG_BIT];
    endproperty
    a_power_path: assert property (p_power_path) else $error("limit flag without charging"); // RULE2

    property p_therm_timer_suspend;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        charging && temp_bad |=> cond_q[COND_THERM_TIMER_SUSPEND_BIT] && !charge_on_o;
    endproperty
    a_therm_timer_suspend: assert property (p_therm_timer_suspend) else $error("suspend not shown"); // RULE3

    property p_term;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        ev_term |=> state_q == CSC_DONE ##1 cond_q[COND_TERM_BIT] && !charge_on_o;
    endproperty
    a_term: assert property (p_term) else $error("termination not flagged"); // RULE4

    property p_active;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        cond_q[COND_ACTIVE_BIT] == charge_on_o;
    endproperty
    a_active: assert property (p_active) else $error("active flag mismatch"); // RULE5

    property p_chg_tout;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        ev_fast_tout |=> state_q == CSC_DONE ##1 cond_q[COND_CHG_TOUT_BIT] && !charge_on_o;
    endproperty
    a_chg_tout: assert property (p_chg_tout) else $error("timeout not flagged"); // RULE6

    property p_pre_tout;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        ev_pre_tout |-> ##2 cond_q[COND_PRE_TOUT_BIT] && cond_q[COND_CHG_TOUT_BIT];
    endproperty
    a_pre_tout: assert property (p_pre_tout) else $error("precharge timeout missed"); // RULE7

    property p_batt_temp;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        ana_q.no_thermistor |=> cond_q[COND_BATT_TEMP_BIT];
    endproperty
    a_batt_temp: assert property (p_batt_temp) else $error("sensor fault missed"); // RULE8

    property p_timer_enable;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !safety_timer_enable && !chg_tout_q |=> !chg_tout_q;
    endproperty
    a_timer_enable: assert property (p_timer_enable) else $error("timeout with timers off"); // RULE10

    property p_restart;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        charger_restart |=> state_q == CSC_IDLE ##1 !charge_on_o;
    endproperty
    a_restart: assert property (p_restart) else $error("restart left charger on"); // RULE12

    property p_term_disable;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        term_disable && !term_q |=> !term_q;
    endproperty
    a_term_disable: assert property (p_term_disable) else $error("terminated while disabled"); // RULE13

    property p_suspend;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        timer_suspend && !pre_exp && state_q == CSC_PRECHG && $past(state_q) == CSC_PRECHG |=> !pre_exp;
    endproperty
    a_suspend: assert property (p_suspend) else $error("timer ran while suspended"); // RULE14

    property p_enable;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !charger_enable |-> ##2 !charge_on_o;
    endproperty
    a_enable: assert property (p_enable) else $error("charger on while disabled"); // RULE15

    property p_setup_write;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        reg_wr_i && reg_addr_i == CSC_ADDR_SETUP |=> setup_q == $past(reg_wdata_i);
    endproperty
    a_setup_write: assert property (p_setup_write) else $error("setup write lost"); // RULE16

    property p_pre_limit;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        pre_limit == (precharge_time_select_i ? SEC_W'(3600) : SEC_W'(1800));
    endproperty
    a_pre_limit: assert property (p_pre_limit) else $error("precharge duration wrong"); // RULE17

    property p_read_clean;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        reg_rd_i && reg_addr_i == CSC_ADDR_CONDITION |=> reg_rdata_o == $past(cond_q);
    endproperty
    a_read_clean: assert property (p_read_clean) else $error("status read wrong"); // RULE18

endmodule // csc_regs

/* File: csc_core_model.sv */
// Charger core stand-in that feeds comparator levels to the register block
module csc_core_model (
    // Clock
    input  wire logic                 ref_clk_i,
    // Bench knobs and charger state
    input  wire csc_pkg::csc_analog_t knob_i,
    input  wire logic                 full_en_i,
    input  wire logic                 charge_on_i,
    // Comparator levels to the block
    output csc_pkg::csc_analog_t      analog_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import csc_pkg::*;

    localparam int FULL_CYC = 40;   // Charge cycles until the cell looks full
    logic [7:0]    on_cnt_q;        // Cycles of delivered charge, saturating

    // Levels follow the knobs one edge late, like a real comparator
    always @(posedge ref_clk_i) begin
        on_cnt_q <= !charge_on_i ? 8'h00 : (on_cnt_q == 8'hFF ? on_cnt_q : on_cnt_q + 8'h01);
        // Slow answer: current only drops once charge has flowed a while (term_current is bit 2)
        analog_o <= knob_i | csc_analog_t'({4'h0, full_en_i && on_cnt_q >= 8'(FULL_CYC), 2'b00});
    end
endmodule // csc_core_model

/* File: tb_csc_regs.sv */
// Self-checking bench for the charger status and setup registers
module tb_csc_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import csc_pkg::*;

    localparam int TICK = 1;           // Short timer second keeps the run brief
    logic          ref_clk_i = 1'b0;
    logic          resetn_i = 1'b0;
    logic          reg_wr_i = 1'b0;
    logic          reg_rd_i = 1'b0;
    logic          pre_sel = 1'b0;     // Precharge length select
    logic          full_en = 1'b0;     // Cell reports full after a while
    logic [7:0]    reg_addr_i = 8'h00;
    logic [7:0]    reg_wdata_i = 8'h00;
    logic [7:0]    reg_rdata_o;
    logic          charge_on_o;
    logic          ntc_o;
    csc_analog_t   knob = '0;
    csc_analog_t   analog;
    int            mismatches = 0;
    int            n_checks = 0;
    logic [15:0]   notes[$];           // Expected value and mask per read
    logic [15:0]   note;
    logic          p1 = 1'b0;
    logic          p2 = 1'b0;
    logic [7:0]    d;
    int            lim;

    always #4 ref_clk_i = ~ref_clk_i;

    csc_regs #(.TICK_CYCLES_P(TICK)) dut_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .analog_i(analog), .precharge_time_select_i(pre_sel),
        .charge_on_o(charge_on_o), .thermistor_type_select_o(ntc_o));
    csc_core_model core_u (.ref_clk_i(ref_clk_i), .knob_i(knob), .full_en_i(full_en),
        .charge_on_i(charge_on_o), .analog_o(analog));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    // Reads are spaced so the held data is still this read's when checked
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        notes.push_back({exp, m});
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
    endtask
    task automatic knobs(input logic [6:0] k);
        @(posedge ref_clk_i);
        knob <= csc_analog_t'(k);
        repeat (6) @(posedge ref_clk_i);
    endtask
    // Bounded wait on the charge output; a timeout ends the run
    task automatic wait_on(input logic v, input int max);
        int i;
        for (i = 0; i < max && charge_on_o !== v; i++) @(posedge ref_clk_i);
        chk("charge_on", {7'h00, v}, {7'h00, charge_on_o});
        if (charge_on_o !== v) print_verdict();
    endtask

    // Read watcher: compares the oldest note once data has settled
    always @(posedge ref_clk_i) begin
        p1 <= reg_rd_i;
        p2 <= p1;
    end
    always @(negedge ref_clk_i) begin
        if (p2) begin
            note = notes.pop_front();
            chk("read data", note[15:8], reg_rdata_o & note[7:0]);
        end
    end

    initial begin
        void'($urandom(67769));
        repeat (12) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        rd(CSC_ADDR_SETUP, CSC_SETUP_RESET);
        rd(CSC_ADDR_CONDITION, 8'h00);
        rd(8'h07, CSC_UNMAPPED_READ);
        chk("ntc", 8'h01, {7'h00, ntc_o});
        $display("test reset done");
        repeat (4) begin
            d = 8'($urandom);
            wr(CSC_ADDR_SETUP, d);
            rd(CSC_ADDR_SETUP, d);
            chk("ntc", {7'h00, d[4]}, {7'h00, ntc_o});
        end
        wr(CSC_ADDR_CONDITION, 8'hFF);
        rd(CSC_ADDR_CONDITION, 8'h00);
        wr(CSC_ADDR_SETUP, 8'hB1);
        $display("test setup done");
        knobs(7'b1100001);
        wait_on(1'b1, 20);
        rd(CSC_ADDR_CONDITION, 8'hC8, 8'hC8);
        rd(CSC_ADDR_CONDITION, 8'hC8, 8'hC8);
        knobs(7'b0000001);
        rd(CSC_ADDR_CONDITION, 8'h08, 8'hC8);
        full_en <= 1'b1;
        wait_on(1'b0, 100);
        rd(CSC_ADDR_CONDITION, 8'h10, 8'h18);
        wr(CSC_ADDR_SETUP, 8'hB9);
        wr(CSC_ADDR_SETUP, 8'hB1);
        wait_on(1'b1, 20);
        wait_on(1'b0, 100);
        wr(CSC_ADDR_SETUP, 8'hBD);
        wr(CSC_ADDR_SETUP, 8'hB5);
        wait_on(1'b1, 20);
        repeat (100) @(posedge ref_clk_i);
        wait_on(1'b1, 1);
        full_en <= 1'b0;
        // Let the full-cell level drain through the synchroniser before re-arming termination
        repeat (4) @(posedge ref_clk_i);
        wr(CSC_ADDR_SETUP, 8'hB1);
        $display("test termination done");
        knobs(7'b0001001);
        rd(CSC_ADDR_CONDITION, 8'h01, 8'h01);
        knobs(7'b0010001);
        rd(CSC_ADDR_CONDITION, 8'h21, 8'h21);
        knobs(7'b0000001);
        wait_on(1'b1, 20);
        wr(CSC_ADDR_SETUP, 8'hB0);
        wait_on(1'b0, 20);
        $display("test temperature and enable done");
        for (int s = 0; s < 2; s++) begin
            pre_sel <= s[0];
            lim = (s ? 60 : 30) * 60 * TICK;
            for (int f = 0; f < 3; f++) begin
                knobs(7'b0000000);
                wr(CSC_ADDR_SETUP, f == 0 ? 8'hB3 : (f == 1 ? 8'h91 : 8'hB1));
                knobs(7'b0000011);
                wait_on(1'b1, 20);
                repeat (f < 2 ? lim + 50 : lim - 30) @(posedge ref_clk_i);
                wait_on(1'b1, 1);
            end
            wait_on(1'b0, 60);
            rd(CSC_ADDR_CONDITION, 8'h06, 8'h0E);
        end
        knobs(7'b0000000);
        wr(CSC_ADDR_SETUP, 8'h31);
        knobs(7'b0000001);
        wait_on(1'b1, 20);
        repeat (240 * 60 * TICK - 30) @(posedge ref_clk_i);
        wait_on(1'b1, 1);
        wait_on(1'b0, 60);
        rd(CSC_ADDR_CONDITION, 8'h04, 8'h06);
        $display("test timers done");
        print_verdict();
    end
endmodule // tb_csc_regs
